// File: rfcfg_bank.v
/*
 * Configuration bank of a sub-GHz transceiver: sync byte, data rate and
 * power management, written as 16-bit serial command words.
 * Assumes a host drives sel_n/sck/sdi pins; analog blocks consume the enables.
 */
// How it works
// - Code 0xce loads the sync byte
// - Sync byte forms the low pattern byte
// - Two-byte pattern prefixes fixed 0x2d
// - Sync register resets to 0xced4
// - Code 0xc6 loads prescaler and rate parameter
// - Prescaler bit slows rate by eight
// - Rate is 10000/(29*(p+1)*(1+7*pre)) kbps
// - Code 0x82 loads power enables, reset 0x8208
// - Bit 7 enables the receiver chain
// - Bit 5 enables transmit; start pulses when tx_reg_en_i is also high
// - Bit 4 enables the synthesizer
// - Bit 3 enables the crystal oscillator
// - Bit 2 enables battery detector
// - Bit 1 enables wake-up timer
// - Bit 0 set turns clock output off
// - Clock output keeps oscillator on, no sleep
// - Reset-mode bit picks normal or sensitive
`timescale 1ns/1ps
`include "rfcfg_regs.vh"

module rfcfg_bank (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire sel_n_i,
    input wire sck_i,
    input wire sdi_i,
    input wire tx_reg_en_i,
    output reg [7:0] pattern_byte_lo_o,
    output reg [7:0] pattern_byte_hi_o,
    output reg pattern_length_sel_o,
    output reg rate_prescale_en_o,
    output reg [6:0] rate_param_o,
    output reg [15:0] rate_divisor_o,
    output reg [31:0] expected_bit_rate_bps_o,
    output reg rx_chain_en_o,
    output reg baseband_en_o,
    output reg rx_ready_o,
    output reg tx_chain_en_o,
    output reg tx_start_o,
    output reg synth_en_o,
    output reg xtal_osc_en_o,
    output reg batt_detect_en_o,
    output reg wake_timer_en_o,
    output reg clk_out_en_o,
    output reg full_sleep_o,
    output reg reset_mode_sel_o,
    output reg sensitive_reset_o
);

////////////////////////////////////////////////////////////////////////////////

wire [2:0] pins_s;
wire word_vld;
wire [15:0] word;

rfcfg_sync2 #(
    .W(3)
) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({sel_n_i, sck_i, sdi_i}),
    .rst_val_i(3'h4),
    .q_o(pins_s)
);

rfcfg_shift_in u_shift (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .sel_n_i(pins_s[2]),
    .sck_i(pins_s[1]),
    .sdi_i(pins_s[0]),
    .word_vld_o(word_vld),
    .word_o(word)
);

////////////////////////////////////////////////////////////////////////////////

reg [15:0] sync_byte_config_ff;
reg [15:0] data_rate_config_ff;
reg [15:0] power_management_config_ff;
reg [15:0] fifo_reset_config_ff;
reg tx_en_prev_ff;

wire [7:0] command_code = word[15:8];

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        sync_byte_config_ff <= `RFCFG_RST_SYNC;
        data_rate_config_ff <= `RFCFG_RST_RATE;
        power_management_config_ff <= `RFCFG_RST_PWR;
        fifo_reset_config_ff <= `RFCFG_RST_FIFO;
    end else if (word_vld) begin
        case (command_code)
            `RFCFG_CODE_SYNC: sync_byte_config_ff <= word;
            `RFCFG_CODE_RATE: data_rate_config_ff <= word;
            `RFCFG_CODE_PWR: power_management_config_ff <= word;
            `RFCFG_CODE_FIFO: fifo_reset_config_ff <= word;
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////

wire [7:0] pm = power_management_config_ff[7:0];
wire pre = data_rate_config_ff[`RFCFG_PRESCALE_BIT];
wire [6:0] param = data_rate_config_ff[6:0];
wire clk_on = ~pm[`RFCFG_PWR_CLKOFF];
wire osc_run = pm[`RFCFG_PWR_OSC] | pm[`RFCFG_PWR_RX] | clk_on;
wire [15:0] nxt_div = ({9'h000, param} + 16'h0001) * (pre ? 16'h0008 : 16'h0001);
wire [31:0] div29 = `RFCFG_RATE_K * {16'h0000, nxt_div};
wire [31:0] nxt_bps = (`RFCFG_RATE_NUM * 32'd1000) / div29;

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        pattern_byte_lo_o <= 8'h00;
        pattern_byte_hi_o <= 8'h00;
        pattern_length_sel_o <= 1'b0;
        rate_prescale_en_o <= 1'b0;
        rate_param_o <= 7'h00;
        rate_divisor_o <= 16'h0000;
        expected_bit_rate_bps_o <= 32'h00000000;
        rx_chain_en_o <= 1'b0;
        baseband_en_o <= 1'b0;
        rx_ready_o <= 1'b0;
        tx_chain_en_o <= 1'b0;
        tx_start_o <= 1'b0;
        tx_en_prev_ff <= 1'b0;
        synth_en_o <= 1'b0;
        xtal_osc_en_o <= 1'b0;
        batt_detect_en_o <= 1'b0;
        wake_timer_en_o <= 1'b0;
        clk_out_en_o <= 1'b0;
        full_sleep_o <= 1'b0;
        reset_mode_sel_o <= 1'b0;
        sensitive_reset_o <= 1'b0;
    end else begin
        pattern_byte_lo_o <= sync_byte_config_ff[7:0];
        pattern_length_sel_o <= fifo_reset_config_ff[`RFCFG_FIFO_LEN_SEL];
        pattern_byte_hi_o <= fifo_reset_config_ff[`RFCFG_FIFO_LEN_SEL] ?
            8'h00 : `RFCFG_PATTERN_HI;
        rate_prescale_en_o <= pre;
        rate_param_o <= param;
        rate_divisor_o <= nxt_div;
        // Rate in bps; the transmitter's tolerance is not checked here
        expected_bit_rate_bps_o <= nxt_bps;
        rx_chain_en_o <= pm[`RFCFG_PWR_RX];
        baseband_en_o <= pm[`RFCFG_PWR_BB];
        rx_ready_o <= pm[`RFCFG_PWR_BB] & osc_run;
        tx_chain_en_o <= pm[`RFCFG_PWR_TX];
        tx_en_prev_ff <= pm[`RFCFG_PWR_TX] & tx_reg_en_i;
        tx_start_o <= pm[`RFCFG_PWR_TX] & tx_reg_en_i & ~tx_en_prev_ff;
        synth_en_o <= pm[`RFCFG_PWR_SYN] | pm[`RFCFG_PWR_RX];
        xtal_osc_en_o <= osc_run;
        batt_detect_en_o <= pm[`RFCFG_PWR_BATT];
        wake_timer_en_o <= pm[`RFCFG_PWR_WAKE];
        clk_out_en_o <= clk_on;
        full_sleep_o <= ~clk_on & ~(|pm[7:1]);
        reset_mode_sel_o <= fifo_reset_config_ff[`RFCFG_FIFO_RSTMODE];
        sensitive_reset_o <= ~fifo_reset_config_ff[`RFCFG_FIFO_RSTMODE];
    end
end

endmodule

// File: rfcfg_bank_properties.sv
/* Port assertions of the configuration bank.
   Assumes binding to rfcfg_bank, one clock domain. */
`timescale 1ns/1ps

module rfcfg_bank_properties (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [7:0] pattern_byte_hi_o,
    input wire pattern_length_sel_o,
    input wire rate_prescale_en_o,
    input wire [6:0] rate_param_o,
    input wire [15:0] rate_divisor_o,
    input wire rx_chain_en_o,
    input wire rx_ready_o,
    input wire tx_chain_en_o,
    input wire tx_start_o,
    input wire synth_en_o,
    input wire xtal_osc_en_o,
    input wire clk_out_en_o,
    input wire full_sleep_o,
    input wire reset_mode_sel_o,
    input wire sensitive_reset_o
);
    reg live_ff = 1'h0;
    always @(posedge clk_sys_i) begin
        live_ff <= rst_n_i;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i || !live_ff);
    a_hi_byte: assert property (pattern_byte_hi_o == (pattern_length_sel_o ? 8'h0 : 8'h2d))
        else $error("bad high pattern byte");
    a_div_calc:
        assert property (rate_divisor_o == ({9'h0, rate_param_o} + 16'h1) * (rate_prescale_en_o ? 8 : 1))
        else $error("bad rate divisor");
    a_div_hold: assert property ($changed(rate_divisor_o) |=> $stable(rate_divisor_o) [*8])
        else $error("rate divisor glitch");
    a_rx_chain: assert property (rx_chain_en_o |-> synth_en_o && xtal_osc_en_o)
        else $error("receiver chain incomplete");
    a_tx_pulse: assert property (tx_start_o |-> tx_chain_en_o ##1 !tx_start_o)
        else $error("bad transmit start");
    a_clk_keep_osc: assert property (clk_out_en_o |-> xtal_osc_en_o && !full_sleep_o)
        else $error("clock output without oscillator");
    a_sleep_off:
        assert property (full_sleep_o |-> !(rx_chain_en_o || synth_en_o || xtal_osc_en_o || clk_out_en_o))
        else $error("sleep with blocks on");
    a_reset_mode: assert property (reset_mode_sel_o != sensitive_reset_o)
        else $error("reset mode outputs clash");
    cover property (tx_start_o);
    cover property (full_sleep_o);
    cover property (rx_ready_o);
endmodule

bind rfcfg_bank rfcfg_bank_properties u_props (.clk_sys_i, .rst_n_i, .pattern_byte_hi_o,
    .pattern_length_sel_o, .rate_prescale_en_o, .rate_param_o, .rate_divisor_o, .rx_chain_en_o,
    .rx_ready_o, .tx_chain_en_o, .tx_start_o, .synth_en_o, .xtal_osc_en_o, .clk_out_en_o,
    .full_sleep_o, .reset_mode_sel_o, .sensitive_reset_o);

// File: rfcfg_bank_test.sv
/* Self-checking bench of the configuration bank.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps

module rfcfg_bank_test;
    reg clk_sys_i = 1'h0;
    reg rst_n_i = 1'h0;
    reg tx_en = 1'h1;
    wire sel_n, sck, sdi, len, pre, rx, bb, rdy, tx, txs, syn, osc, bat, wak, cko, slp, rsm, sen;
    wire [7:0] lo, hi;
    wire [6:0] par;
    wire [15:0] div;
    wire [31:0] bps;
    integer error_cnt = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer i;
    reg [31:0] r;
    reg [31:0] rows [0:11];

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    rfcfg_host u_host (.clk_i(clk_sys_i), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi));
    rfcfg_bank u_dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n), .sck_i(sck), .sdi_i(sdi),
        .tx_reg_en_i(tx_en), .pattern_byte_lo_o(lo), .pattern_byte_hi_o(hi),
        .pattern_length_sel_o(len), .rate_prescale_en_o(pre), .rate_param_o(par),
        .rate_divisor_o(div), .expected_bit_rate_bps_o(bps), .rx_chain_en_o(rx),
        .baseband_en_o(bb), .rx_ready_o(rdy), .tx_chain_en_o(tx), .tx_start_o(txs),
        .synth_en_o(syn), .xtal_osc_en_o(osc), .batt_detect_en_o(bat),
        .wake_timer_en_o(wak), .clk_out_en_o(cko), .full_sleep_o(slp),
        .reset_mode_sel_o(rsm), .sensitive_reset_o(sen)
    );

    function [15:0] obs(input [7:0] code);
        case (code)
            8'hce: obs = {hi, lo};
            8'hc6: obs = div;
            8'h82: obs = {7'h0, slp, rx, bb, tx, syn, osc, bat, wak, cko};
            default: obs = {hi, 6'h0, len, rsm};
        endcase
    endfunction

    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks++;
            if (seen !== exp) begin
                error_cnt++;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            summarize;
        end
    end

    initial begin
        rows = '{32'hce5a2d5a, 32'hc6000001, 32'hc6ff0400, 32'hc67f0080, 32'h82800099,
                 32'h82010100, 32'h82100019, 32'h82490048, 32'h82070006, 32'h82210020,
                 32'hca080002, 32'hca012d01};
        repeat (20) @(posedge clk_sys_i);
        #1 rst_n_i = 1'h1;
        u_host.tick(4);
        check({hi, lo, div}, 32'h2dd40024);
        check(bps, 32'h256a);
        check({obs(8'h82), 13'h0, len, rsm, sen}, 32'h00090001);
        $display("reset test done");
        for (i = 0; i < 12; i++) begin
            r = rows[i];
            u_host.frame(r[31:16], 1'h0);
            u_host.tick(4);
            check(obs(r[31:24]), r[15:0]);
        end
        $display("row test done");
        // Transmit chain is on; start pulses when the transmit register enables
        tx_en = 1'h0;
        u_host.tick(2);
        tx_en = 1'h1;
        u_host.tick(1);
        check({31'h0, txs}, 32'h1);
        u_host.tick(1);
        check({31'h0, txs}, 32'h0);
        // Baseband alone is not ready; with the oscillator it is
        u_host.frame(16'h8241, 1'h0);
        u_host.tick(4);
        check({31'h0, rdy}, 32'h0);
        u_host.frame(16'h8248, 1'h0);
        u_host.tick(4);
        check({31'h0, rdy}, 32'h1);
        $display("transmit and ready test done");
        // Cut word, unknown code, then a good word
        u_host.frame(16'hc6ff, 1'h1);
        u_host.frame(16'hc5ff, 1'h0);
        u_host.frame(16'hce0f, 1'h0);
        u_host.tick(4);
        check({div, 8'h0, lo}, 32'h0080000f);
        check(bps, 32'h0a85);
        $display("abort test done");
        rst_n_i = 1'h0;
        u_host.tick(4);
        rst_n_i = 1'h1;
        u_host.tick(4);
        check({obs(8'h82), hi, lo}, 32'h00092dd4);
        $display("second reset test done");
        summarize;
    end
endmodule

// File: rfcfg_host.sv
/* Host model sending command words on the select, clock and data pins.
   Assumes four system clocks per serial clock phase. */
`timescale 1ns/1ps

module rfcfg_host (
    input wire clk_i,
    output reg sel_n_o = 1'h1,
    output reg sck_o = 1'h0,
    output reg sdi_o = 1'h0
);
    // Fixed bit timing keeps the sender's rate error at zero
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Word MSB first; cut drops select after the code byte
    task frame(input [15:0] w, input bit cut);
        integer i;
        begin
            tick(4);
            sel_n_o = 1'h0;
            for (i = 15; i >= (cut ? 8 : 0); i--) begin
                sdi_o = w[i];
                tick(4);
                sck_o = 1'h1;
                tick(4);
                sck_o = 1'h0;
            end
            tick(8);
            sel_n_o = 1'h1;
            sdi_o = ~sdi_o;
        end
    endtask
endmodule

// File: rfcfg_regs.vh
/*
 * Constants of the transceiver configuration bank: command codes, reset words,
 * field positions and the rate arithmetic figures.
 * Assumes inclusion by design files only; definitions, no logic.
 */
`ifndef RFCFG_REGS_VH
`define RFCFG_REGS_VH

`define RFCFG_WORD_W 16
`define RFCFG_CNT_W 5
`define RFCFG_CNT_LAST 5'h0f
`define RFCFG_CODE_SYNC 8'hce
`define RFCFG_CODE_RATE 8'hc6
`define RFCFG_CODE_PWR 8'h82
`define RFCFG_CODE_FIFO 8'hca
`define RFCFG_RST_SYNC 16'hced4
`define RFCFG_RST_RATE 16'hc623
`define RFCFG_RST_PWR 16'h8208
`define RFCFG_RST_FIFO 16'hca80
`define RFCFG_PATTERN_HI 8'h2d
`define RFCFG_PRESCALE_BIT 7
`define RFCFG_PWR_RX 7
`define RFCFG_PWR_BB 6
`define RFCFG_PWR_TX 5
`define RFCFG_PWR_SYN 4
`define RFCFG_PWR_OSC 3
`define RFCFG_PWR_BATT 2
`define RFCFG_PWR_WAKE 1
`define RFCFG_PWR_CLKOFF 0
`define RFCFG_FIFO_LEN_SEL 3
`define RFCFG_FIFO_RSTMODE 0
`define RFCFG_RATE_NUM 32'd10000
`define RFCFG_RATE_K 32'd29
`define RFCFG_PRE_MUL 32'd7

`endif

// File: rfcfg_shift_in.v
/*
 * Serial command word receiver: shifts a 16-bit word in, MSB first, on
 * rising edges of the serial clock while select is low.
 * Assumes pins already passed two flip-flops in the system clock domain.
 */
`timescale 1ns/1ps
`include "rfcfg_regs.vh"

module rfcfg_shift_in (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire sel_n_i,
    input wire sck_i,
    input wire sdi_i,
    output reg word_vld_o,
    output reg [15:0] word_o
);

reg sck_prev_ff;
reg [`RFCFG_CNT_W-1:0] cnt_ff;
reg [15:0] shift_ff;

wire sck_rise = sck_i & ~sck_prev_ff;

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        sck_prev_ff <= 1'b0;
        cnt_ff <= {`RFCFG_CNT_W{1'b0}};
        shift_ff <= 16'h0000;
        word_vld_o <= 1'b0;
        word_o <= 16'h0000;
    end else begin
        sck_prev_ff <= sck_i;
        word_vld_o <= 1'b0;
        if (sel_n_i) begin
            // Deselect drops a partial word
            cnt_ff <= {`RFCFG_CNT_W{1'b0}};
        end else if (sck_rise) begin
            shift_ff <= {shift_ff[14:0], sdi_i};
            if (cnt_ff == `RFCFG_CNT_LAST) begin
                word_o <= {shift_ff[14:0], sdi_i};
                word_vld_o <= 1'b1;
                cnt_ff <= {`RFCFG_CNT_W{1'b0}};
            end else begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end
end

endmodule

// File: rfcfg_sync2.v
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes asynchronous inputs; output is usable in the system clock domain.
 */
`timescale 1ns/1ps

module rfcfg_sync2 #(
    parameter W = 3
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [W-1:0] d_i,
    input wire [W-1:0] rst_val_i,
    output wire [W-1:0] q_o
);

reg [W-1:0] s1_ff;
reg [W-1:0] s2_ff;

always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
        s1_ff <= {W{1'b0}};
        s2_ff <= {W{1'b0}};
    end else begin
        s1_ff <= d_i;
        s2_ff <= s1_ff;
    end
end

// Constant reset value is applied after the second stage
assign q_o = rst_n_i ? s2_ff : rst_val_i;

endmodule
